// ### scasy_defines.vh
`ifndef SCASY_DEFINES_VH
`define SCASY_DEFINES_VH
// Register addresses
`define SCASY_ADDR_ALIGN_MODE   8'hB8
`define SCASY_ADDR_ROTATION     8'hB9
`define SCASY_ADDR_AVERAGE      8'hBA
`define SCASY_ADDR_TRIG         8'hBC
`define SCASY_ADDR_RATIO        8'hBD
`define SCASY_ADDR_AVG_PATH     8'hC5
`define SCASY_ADDR_PERIOD_LO    8'hC7
`define SCASY_ADDR_PERIOD_HI    8'hC8
`define SCASY_ADDR_EDGE_SEL     8'hCB
`define SCASY_ADDR_LF_CTRL      8'hCC
`define SCASY_ADDR_GPIO_CFG0    8'h35
`define SCASY_ADDR_GPIO_CFG1    8'h36
`define SCASY_ADDR_GPIO_CFG2    8'h37
// Field positions
`define SCASY_BIT_CONT          0
`define SCASY_BIT_ONESHOT       1
`define SCASY_BIT_DONE          4
`define SCASY_BIT_NCORST        4
`define SCASY_BIT_AVG_PATH      5
`define SCASY_BIT_PERIOD_SEL    4
// Reset values
`define SCASY_RST_ROTATION      8'h30
`define SCASY_RST_AVG_PATH      8'h07
`define SCASY_RST_PERIOD_LO     8'h80
`define SCASY_RST_PERIOD_HI     3'h1
`define SCASY_RST_EDGE_SEL      8'h15
`define SCASY_RST_LF_CTRL       8'h04
// Pin function codes
`define SCASY_GPIO_LEADER_OUT   4'hA
`define SCASY_GPIO_FOLLOW_IN    4'hB
// Timing counts
`define SCASY_ROT_CYCLES        4'h8
`define SCASY_PWR_CYCLES        4'h4
`define SCASY_DEFAULT_JESD_PER  11'h080
`endif

// ### scasy_sysref_align.v
`timescale 1ns/100ps
`include "scasy_defines.vh"

module scasy_sysref_align
(
  input  wire        mclk_i,          // Divided DAC clock
  input  wire        rst_n_i,         // Async reset, active low
  input  wire        reg_wr_i,        // Register write strobe
  input  wire        reg_rd_i,        // Register read strobe
  input  wire [7:0]  reg_addr_i,      // Register address
  input  wire [7:0]  reg_wdata_i,     // Write data
  output reg  [7:0]  reg_rdata_o,     // Read data
  input  wire        sysref_i,        // SYSREF pulse, external
  input  wire        subclass1_i,     // Link subclass select
  input  wire        jesd_period_en_i,// Link frame-period tick
  input  wire [5:0]  gpio_i,          // Pin inputs
  output reg  [5:0]  gpio_o,          // Pin outputs
  output reg  [5:0]  gpio_oe_o,       // Pin drive enables
  output reg         link_down_o,     // Serial link held down
  output reg         dp_off_o,        // Datapath soft-off request
  output reg         clk_rotate_o,    // Clock rotation pulse
  output reg         nco_rst_o,       // NCO reset pulse, both paths
  output reg         rx_nco_sync_o,   // Rx NCO sync pulse
  output reg         tx_nco_sync_o,   // Tx NCO sync pulse
  output reg         lmfc_o           // Internal frame clock
);

  // Sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_PRE  = 2'b01;
  localparam ST_ROT  = 2'b10;
  localparam ST_POST = 2'b11;

  // Alignment behaviour register value at reset
  localparam [7:0] ROT_RST = `SCASY_RST_ROTATION;

  // Software-visible fields
  reg        cont_en_reg;             // continuous_align_enable
  reg        oneshot_reg;             // single_align_enable
  reg        done_reg;                // One-shot done flag
  reg        nco_after_reg;           // osc_reset_after_align
  reg [1:0]  rot_mode_reg;            // Alignment behaviour
  reg [2:0]  avg_cnt_reg;             // sysref_pulse_avg_count
  reg        trig_reg;                // leader_sync_trigger
  reg [3:0]  ratio_reg;               // rx_tx_frame_ratio
  reg        avg_path_reg;            // avg_path_enable
  reg [7:0]  per_lo_reg;              // Manual period low byte
  reg [2:0]  per_hi_reg;              // Manual period high bits
  reg        per_sel_reg;             // manual_period_select
  reg [1:0]  rx_edge_reg;             // rx_osc_sync_edge
  reg [1:0]  tx_edge_reg;             // tx_osc_sync_edge
  reg [3:0]  extra_reg;               // extra_frame_delay
  reg [1:0]  src_reg;                 // leader_trigger_source
  reg [1:0]  role_reg;                // leader_follower_role
  reg [23:0] gpio_cfg_reg;            // Six 4-bit pin configs

  // Synchronisers and edge state
  reg        sref_m_reg;
  reg        sref_s_reg;
  reg        sref_d_reg;
  reg [5:0]  gpio_m_reg;
  reg [5:0]  gpio_s_reg;
  reg        fol_d_reg;

  // Frame clock counter
  reg [10:0] lmfc_cnt_reg;
  reg        lmfc_d_reg;

  // Sequencer
  reg [1:0]  state_reg;
  reg [3:0]  seq_cnt_reg;
  reg        from_oneshot_reg;
  reg        init_rst_reg;            // Pending post-reset NCO clear

  // Pending NCO edge syncs
  reg        rx_pend_reg;
  reg        tx_pend_reg;

  // Leader/follower engine
  reg        lf_arm_reg;              // Waiting for trigger source
  reg        lf_wait_reg;             // Counting extra frames
  reg [3:0]  lf_cnt_reg;
  reg        lf_pulse_reg;            // Leader sync out level

  // Derived combinational terms
  wire       sref_rise = sref_s_reg & ~sref_d_reg;
  wire [10:0] period =
    per_sel_reg ? {per_hi_reg, per_lo_reg}
                : `SCASY_DEFAULT_JESD_PER;
  wire       lmfc_rise = lmfc_o & ~lmfc_d_reg;
  wire       lmfc_fall = ~lmfc_o & lmfc_d_reg;
  wire       wr_trig   = reg_wr_i & (reg_addr_i == `SCASY_ADDR_TRIG)
                         & reg_wdata_i[0];
  wire       is_leader   = (role_reg == 2'b01);
  wire       is_follower = (role_reg == 2'b10);
  reg        fol_in;
  reg        src_hit;
  reg        rx_hit;
  reg        tx_hit;
  integer    i;                       // Pin index, follower scan
  integer    j;                       // Pin index, pin drivers

  // Follower input: any pin configured as sync input
  always @*
  begin
    fol_in = 1'b0;
    for (i = 0; i < 6; i = i + 1)
      if (gpio_cfg_reg[i*4 +: 4] == `SCASY_GPIO_FOLLOW_IN)
        fol_in = fol_in | gpio_s_reg[i];
  end

  // Event selectors for edges and trigger source
  always @*
  begin
    case (src_reg)
      2'b00:   src_hit = sref_rise;
      2'b01:   src_hit = lmfc_rise;
      2'b10:   src_hit = lmfc_fall;
      default: src_hit = 1'b0;
    endcase
    case (rx_edge_reg)
      2'b01:   rx_hit = lmfc_rise;
      2'b10:   rx_hit = lmfc_fall;
      default: rx_hit = 1'b0;
    endcase
    case (tx_edge_reg)
      2'b01:   tx_hit = lmfc_rise;
      2'b10:   tx_hit = lmfc_fall;
      default: tx_hit = 1'b0;
    endcase
  end

  // Input synchronisers
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sref_m_reg <= 1'b0;
      sref_s_reg <= 1'b0;
      sref_d_reg <= 1'b0;
      gpio_m_reg <= 6'h00;
      gpio_s_reg <= 6'h00;
      fol_d_reg  <= 1'b0;
    end
    else
    begin
      sref_m_reg <= sysref_i;
      sref_s_reg <= sref_m_reg;
      sref_d_reg <= sref_s_reg;
      gpio_m_reg <= gpio_i;
      gpio_s_reg <= gpio_m_reg;
      fol_d_reg  <= fol_in;
    end
  end

  // Frame clock: high for first half of period
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lmfc_cnt_reg <= 11'h000;
      lmfc_o       <= 1'b0;
      lmfc_d_reg   <= 1'b0;
    end
    else
    begin
      lmfc_d_reg <= lmfc_o;
      // Rotation restarts the frame; a period of N spans N steps
      if (clk_rotate_o)
        lmfc_cnt_reg <= 11'h000;
      else if (per_sel_reg || jesd_period_en_i)
      begin
        if (lmfc_cnt_reg + 11'h001 >= period)
          lmfc_cnt_reg <= 11'h000;
        else
          lmfc_cnt_reg <= lmfc_cnt_reg + 11'h001;
      end
      lmfc_o <= (lmfc_cnt_reg < {1'b0, period[10:1]});
    end
  end

  // Register writes, alignment sequencer and sync engines
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cont_en_reg   <= 1'b0;
      oneshot_reg   <= 1'b0;
      done_reg      <= 1'b0;
      nco_after_reg <= ROT_RST[`SCASY_BIT_NCORST];
      rot_mode_reg  <= 2'b00;
      avg_cnt_reg   <= 3'h0;
      trig_reg      <= 1'b0;
      ratio_reg     <= 4'h0;
      avg_path_reg  <= 1'b0;
      per_lo_reg    <= `SCASY_RST_PERIOD_LO;
      per_hi_reg    <= `SCASY_RST_PERIOD_HI;
      per_sel_reg   <= 1'b0;
      rx_edge_reg   <= 2'b01;
      tx_edge_reg   <= 2'b01;
      extra_reg     <= 4'h0;
      src_reg       <= 2'b01;
      role_reg      <= 2'b00;
      gpio_cfg_reg  <= 24'h000000;
      state_reg     <= ST_IDLE;
      seq_cnt_reg   <= 4'h0;
      from_oneshot_reg <= 1'b0;
      init_rst_reg  <= 1'b1;
      rx_pend_reg   <= 1'b0;
      tx_pend_reg   <= 1'b0;
      lf_arm_reg    <= 1'b0;
      lf_wait_reg   <= 1'b0;
      lf_cnt_reg    <= 4'h0;
      lf_pulse_reg  <= 1'b0;
      link_down_o   <= 1'b0;
      dp_off_o      <= 1'b0;
      clk_rotate_o  <= 1'b0;
      nco_rst_o     <= 1'b0;
      rx_nco_sync_o <= 1'b0;
      tx_nco_sync_o <= 1'b0;
    end
    else
    begin
      clk_rotate_o  <= 1'b0;
      nco_rst_o     <= 1'b0;
      rx_nco_sync_o <= 1'b0;
      tx_nco_sync_o <= 1'b0;
      init_rst_reg  <= 1'b0;
      // NCO clear after digital reset
      if (init_rst_reg && nco_after_reg)
        nco_rst_o <= 1'b1;

      // Software writes; address decode chain
      if (reg_wr_i)
      begin
        if (reg_addr_i == `SCASY_ADDR_ALIGN_MODE)
        begin
          cont_en_reg <= reg_wdata_i[`SCASY_BIT_CONT];
          oneshot_reg <= reg_wdata_i[`SCASY_BIT_ONESHOT];
          if (reg_wdata_i[`SCASY_BIT_ONESHOT])
            done_reg <= 1'b0;
        end
        else if (reg_addr_i == `SCASY_ADDR_ROTATION)
        begin
          nco_after_reg <= reg_wdata_i[`SCASY_BIT_NCORST];
          rot_mode_reg  <= reg_wdata_i[1:0];
        end
        else if (reg_addr_i == `SCASY_ADDR_AVERAGE)
          avg_cnt_reg <= reg_wdata_i[2:0];  // Zero means sampled
        else if (reg_addr_i == `SCASY_ADDR_RATIO)
          ratio_reg <= reg_wdata_i[3:0];
        else if (reg_addr_i == `SCASY_ADDR_AVG_PATH)
          avg_path_reg <= reg_wdata_i[`SCASY_BIT_AVG_PATH];
        else if (reg_addr_i == `SCASY_ADDR_PERIOD_LO)
          per_lo_reg <= reg_wdata_i;
        else if (reg_addr_i == `SCASY_ADDR_PERIOD_HI)
        begin
          per_sel_reg <= reg_wdata_i[`SCASY_BIT_PERIOD_SEL];
          per_hi_reg  <= reg_wdata_i[2:0];
        end
        else if (reg_addr_i == `SCASY_ADDR_EDGE_SEL)
        begin
          rx_edge_reg <= reg_wdata_i[3:2];
          tx_edge_reg <= reg_wdata_i[1:0];
        end
        else if (reg_addr_i == `SCASY_ADDR_LF_CTRL)
        begin
          extra_reg <= reg_wdata_i[7:4];
          src_reg   <= reg_wdata_i[3:2];
          role_reg  <= reg_wdata_i[1:0];
        end
        else if (reg_addr_i == `SCASY_ADDR_GPIO_CFG0)
          gpio_cfg_reg[7:0] <= reg_wdata_i;
        else if (reg_addr_i == `SCASY_ADDR_GPIO_CFG1)
          gpio_cfg_reg[15:8] <= reg_wdata_i;
        else if (reg_addr_i == `SCASY_ADDR_GPIO_CFG2)
          gpio_cfg_reg[23:16] <= reg_wdata_i;
      end

      // Alignment sequencer
      case (state_reg)
        ST_IDLE:
        begin
          if ((cont_en_reg && sref_rise) ||
              (oneshot_reg && !done_reg &&
               (sref_rise || !subclass1_i)))
          begin
            from_oneshot_reg <= ~cont_en_reg;
            link_down_o <= rot_mode_reg[0];
            dp_off_o    <= rot_mode_reg[1];
            seq_cnt_reg <= (rot_mode_reg == 2'b00) ? 4'h0
                           : `SCASY_PWR_CYCLES;
            state_reg   <= ST_PRE;
          end
        end
        ST_PRE:
        begin
          // Let link and datapath settle off
          if (seq_cnt_reg == 4'h0)
          begin
            clk_rotate_o <= 1'b1;
            seq_cnt_reg  <= `SCASY_ROT_CYCLES;
            state_reg    <= ST_ROT;
          end
          else
            seq_cnt_reg <= seq_cnt_reg - 4'h1;
        end
        ST_ROT:
        begin
          if (seq_cnt_reg == 4'h0)
          begin
            link_down_o <= 1'b0;
            dp_off_o    <= 1'b0;
            state_reg   <= ST_POST;
          end
          else
            seq_cnt_reg <= seq_cnt_reg - 4'h1;
        end
        default:
        begin
          // Completion: one-shot flag and optional NCO clear
          if (from_oneshot_reg)
          begin
            done_reg    <= 1'b1;
            oneshot_reg <= 1'b0;
            if (nco_after_reg)
              nco_rst_o <= 1'b1;
          end
          state_reg <= ST_IDLE;
        end
      endcase

      // Rx/Tx NCO sync on SYSREF-selected edge
      if (sref_rise && rx_edge_reg == 2'b00)
        rx_nco_sync_o <= 1'b1;
      else if (sref_rise && rx_edge_reg != 2'b11)
        rx_pend_reg <= 1'b1;
      else if (rx_pend_reg && rx_hit)
      begin
        rx_nco_sync_o <= 1'b1;
        rx_pend_reg   <= 1'b0;
      end
      if (sref_rise && tx_edge_reg == 2'b00)
        tx_nco_sync_o <= 1'b1;
      else if (sref_rise && tx_edge_reg != 2'b11)
        tx_pend_reg <= 1'b1;
      else if (tx_pend_reg && tx_hit)
      begin
        tx_nco_sync_o <= 1'b1;
        tx_pend_reg   <= 1'b0;
      end

      // Leader engine: trigger, source, extra frames
      lf_pulse_reg <= 1'b0;
      if (wr_trig && is_leader)
      begin
        trig_reg   <= 1'b1;
        lf_arm_reg <= 1'b1;
      end
      else if (wr_trig)
        trig_reg <= 1'b1;
      else if (trig_reg && !lf_arm_reg && !lf_wait_reg)
        trig_reg <= 1'b0;
      if (lf_arm_reg && src_hit)
      begin
        lf_arm_reg <= 1'b0;
        if (src_reg != 2'b00 && extra_reg != 4'h0)
        begin
          lf_wait_reg <= 1'b1;
          lf_cnt_reg  <= extra_reg;
        end
        else
        begin
          nco_rst_o    <= 1'b1;
          lf_pulse_reg <= 1'b1;
        end
      end
      else if (lf_wait_reg && lmfc_rise)
      begin
        if (lf_cnt_reg == 4'h1)
        begin
          lf_wait_reg  <= 1'b0;
          nco_rst_o    <= 1'b1;
          lf_pulse_reg <= 1'b1;
        end
        lf_cnt_reg <= lf_cnt_reg - 4'h1;
      end
      if (!is_leader)
      begin
        lf_arm_reg  <= 1'b0;
        lf_wait_reg <= 1'b0;
      end

      // Follower: reset NCOs on sync input edge
      if (is_follower && fol_in && !fol_d_reg)
        nco_rst_o <= 1'b1;
    end
  end

  // Pin drivers for leader sync output
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gpio_o    <= 6'h00;
      gpio_oe_o <= 6'h00;
    end
    else
    begin
      for (j = 0; j < 6; j = j + 1)
      begin
        gpio_oe_o[j] <= (gpio_cfg_reg[j*4 +: 4] ==
                         `SCASY_GPIO_LEADER_OUT);
        gpio_o[j]    <= lf_pulse_reg &
                        (gpio_cfg_reg[j*4 +: 4] ==
                         `SCASY_GPIO_LEADER_OUT);
      end
    end
  end

  // Registered read data
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      if (reg_addr_i == `SCASY_ADDR_ALIGN_MODE)
        reg_rdata_o <= {3'h0, done_reg, 2'h0, oneshot_reg, cont_en_reg};
      else if (reg_addr_i == `SCASY_ADDR_ROTATION)
        reg_rdata_o <= {3'h1, nco_after_reg, 2'h0, rot_mode_reg};
      else if (reg_addr_i == `SCASY_ADDR_AVERAGE)
        reg_rdata_o <= {5'h00, avg_cnt_reg};
      else if (reg_addr_i == `SCASY_ADDR_TRIG)
        reg_rdata_o <= {7'h00, trig_reg};
      else if (reg_addr_i == `SCASY_ADDR_RATIO)
        reg_rdata_o <= {4'h0, ratio_reg};
      else if (reg_addr_i == `SCASY_ADDR_AVG_PATH)
        reg_rdata_o <= {2'h0, avg_path_reg, 5'h07};
      else if (reg_addr_i == `SCASY_ADDR_PERIOD_LO)
        reg_rdata_o <= per_lo_reg;
      else if (reg_addr_i == `SCASY_ADDR_PERIOD_HI)
        reg_rdata_o <= {3'h0, per_sel_reg, 1'b0, per_hi_reg};
      else if (reg_addr_i == `SCASY_ADDR_EDGE_SEL)
        reg_rdata_o <= {4'h1, rx_edge_reg, tx_edge_reg};
      else if (reg_addr_i == `SCASY_ADDR_LF_CTRL)
        reg_rdata_o <= {extra_reg, src_reg, role_reg};
      else if (reg_addr_i == `SCASY_ADDR_GPIO_CFG0)
        reg_rdata_o <= gpio_cfg_reg[7:0];
      else if (reg_addr_i == `SCASY_ADDR_GPIO_CFG1)
        reg_rdata_o <= gpio_cfg_reg[15:8];
      else if (reg_addr_i == `SCASY_ADDR_GPIO_CFG2)
        reg_rdata_o <= gpio_cfg_reg[23:16];
      else
        reg_rdata_o <= 8'h00;  // Unmapped reads zero
    end
  end

endmodule

// ### scasy_sysref_align_monitor.sv
`timescale 1ns/100ps
module scasy_sysref_align_monitor
(
  input wire       mclk_i,           // Device clock
  input wire       rst_n_i,          // Reset, active low
  input wire       reg_wr_i,         // Write strobe
  input wire       reg_rd_i,         // Read strobe
  input wire [7:0] reg_addr_i,       // Address
  input wire [7:0] reg_wdata_i,      // Write data
  input wire [7:0] reg_rdata_o,      // Read data
  input wire       sysref_i,         // SYSREF pin
  input wire       subclass1_i,      // Subclass select
  input wire       jesd_period_en_i, // Link period tick
  input wire [5:0] gpio_i,           // Pin inputs
  input wire [5:0] gpio_o,           // Pin outputs
  input wire [5:0] gpio_oe_o,        // Pin enables
  input wire       link_down_o,      // Link held down
  input wire       dp_off_o,         // Datapath off
  input wire       clk_rotate_o,     // Rotation pulse
  input wire       nco_rst_o,        // NCO reset pulse
  input wire       rx_nco_sync_o,    // Rx sync pulse
  input wire       tx_nco_sync_o,    // Tx sync pulse
  input wire       lmfc_o            // Frame clock
);
  reg  [1:0]  mode_sh; // Alignment behaviour copy
  reg  [3:0]  edge_sh; // Sync edge copy
  reg  [23:0] cfg_sh;  // Pin config copy
  reg  [5:0]  oe_exp;  // Pins expected to drive
  integer     i;       // Pin index
  // Track register writes
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_sh <= 2'h0;
      edge_sh <= 4'h5;
      cfg_sh  <= 24'h000000;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == 8'hB9)
        mode_sh <= reg_wdata_i[1:0];
      if (reg_addr_i == 8'hCB)
        edge_sh <= reg_wdata_i[3:0];
      if (reg_addr_i == 8'h35)
        cfg_sh[7:0] <= reg_wdata_i;
      if (reg_addr_i == 8'h36)
        cfg_sh[15:8] <= reg_wdata_i;
      if (reg_addr_i == 8'h37)
        cfg_sh[23:16] <= reg_wdata_i;
    end
  end
  // Leader output pins from configs
  always @*
  begin
    for (i = 0; i < 6; i = i + 1)
      oe_exp[i] = (cfg_sh[4*i +: 4] == 4'hA);
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_rot_single: assert property (clk_rotate_o |=> !clk_rotate_o)
    else $error("rotate pulse too long");
  a_nco_single: assert property (nco_rst_o |=> !nco_rst_o)
    else $error("nco reset pulse too long");
  a_link_mode: assert property (link_down_o |-> mode_sh[0])
    else $error("link down in wrong mode");
  a_dp_mode: assert property (dp_off_o |-> mode_sh[1])
    else $error("datapath off in wrong mode");
  a_down_first: assert property (clk_rotate_o |->
    {dp_off_o, link_down_o} == mode_sh)
    else $error("power state wrong at rotation");
  a_restore_bound: assert property ($rose(clk_rotate_o) |->
    ##[1:12] (!link_down_o && !dp_off_o))
    else $error("link or datapath not restored");
  a_oe_match: assert property ($stable(oe_exp)[*3] |->
    gpio_oe_o == oe_exp)
    else $error("pin enable does not match config");
  a_out_enabled: assert property ((gpio_o & ~gpio_oe_o) == 6'h00)
    else $error("pin pulses while not enabled");
  a_tx_edge0: assert property ((edge_sh[1:0] == 2'h0) &&
    $rose(sysref_i) |-> ##[2:6] tx_nco_sync_o)
    else $error("tx sync missing after SYSREF");
  a_rx_edge0: assert property ((edge_sh[3:2] == 2'h0) &&
    $rose(sysref_i) |-> ##[2:6] rx_nco_sync_o)
    else $error("rx sync missing after SYSREF");
endmodule
bind scasy_sysref_align scasy_sysref_align_monitor u_mon
(
  .mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .reg_rdata_o, .sysref_i, .subclass1_i, .jesd_period_en_i, .gpio_i,
  .gpio_o, .gpio_oe_o, .link_down_o, .dp_off_o, .clk_rotate_o,
  .nco_rst_o, .rx_nco_sync_o, .tx_nco_sync_o, .lmfc_o
);

// ### scasy_peer_model.sv
`timescale 1ns/100ps
module scasy_peer_model
(
  input  wire       mclk_i,   // Device clock
  output reg        sysref_o, // SYSREF to device
  output reg  [5:0] sync_o    // Leader sync into device pins
);
  // Lines driven low when idle
  initial
  begin
    sysref_o = 1'b0;
    sync_o   = 6'h00;
  end
  // One SYSREF pulse, four clocks wide
  task send_sysref;
  begin
    @(posedge mclk_i);
    sysref_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    sysref_o <= 1'b0;
  end
  endtask
  // Leader sync pulse on chosen pins
  task send_sync(input [5:0] pins);
  begin
    @(posedge mclk_i);
    sync_o <= pins;
    repeat (4) @(posedge mclk_i);
    sync_o <= 6'h00;
  end
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
`include "scasy_defines.vh"
module tb_top;
  reg        mclk_i, rst_n_i, reg_wr_i, reg_rd_i, subclass1_i;
  reg        jesd_period_en_i;
  reg  [7:0] reg_addr_i, reg_wdata_i;
  wire [7:0] reg_rdata_o;
  wire [5:0] gpio_i, gpio_o, gpio_oe_o;
  wire       sysref_i, link_down_o, dp_off_o, clk_rotate_o, nco_rst_o;
  wire       rx_nco_sync_o, tx_nco_sync_o, lmfc_o;
  integer    err_count, check_count, cyc, rot_n, nco_n, txs_n, rxs_n;
  integer    lr_n, lo_n, last_r, per_q, p4, n0, r0, d;
  reg  [1:0] down_at; // Power state at rotation
  reg        lm_q;    // Frame clock delayed
  reg  [7:0] m, v;    // Loop value, read data
  scasy_sysref_align dut
  (
    .mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .sysref_i, .subclass1_i, .jesd_period_en_i, .gpio_i,
    .gpio_o, .gpio_oe_o, .link_down_o, .dp_off_o, .clk_rotate_o,
    .nco_rst_o, .rx_nco_sync_o, .tx_nco_sync_o, .lmfc_o
  );
  scasy_peer_model peer (.mclk_i, .sysref_o(sysref_i), .sync_o(gpio_i));
  always #20 mclk_i = ~mclk_i;
  // Event counters, link tick and timeout
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    jesd_period_en_i <= (cyc % 4 == 0);
    lm_q <= lmfc_o;
    if (clk_rotate_o) rot_n <= rot_n + 1;
    if (clk_rotate_o) down_at <= {dp_off_o, link_down_o};
    if (nco_rst_o) nco_n <= nco_n + 1;
    if (tx_nco_sync_o) txs_n <= txs_n + 1;
    if (rx_nco_sync_o) rxs_n <= rxs_n + 1;
    if (gpio_o[0]) lo_n <= lo_n + 1;
    if (lmfc_o && !lm_q) lr_n <= lr_n + 1;
    if (lmfc_o && !lm_q) last_r <= cyc;
    if (lmfc_o && !lm_q) per_q <= cyc - last_r;
    if (cyc == 20000) err_count = err_count + 1;
    if (cyc == 20000) stop_test;
  end
  task chk8(input string nm, input [7:0] e, input [7:0] g);
  begin
    check_count = check_count + 1;
    if (g !== e) err_count = err_count + 1;
    if (g !== e) $display("BAD %s exp %h got %h", nm, e, g);
  end
  endtask
  task chki(input string nm, input integer e, input integer g);
  begin
    check_count = check_count + 1;
    if (g !== e) err_count = err_count + 1;
    if (g !== e) $display("BAD %s exp %0d got %0d", nm, e, g);
  end
  endtask
  task wr(input [7:0] a, input [7:0] dd);
  begin
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= dd;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
  begin
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk8("reg", e, reg_rdata_o);
  end
  endtask
  // Reset, then the one NCO clear that follows it
  task do_reset;
  begin
    rst_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    n0 = nco_n;
    repeat (4) @(posedge mclk_i);
    chki("post reset nco", n0 + 1, nco_n);
  end
  endtask
  // Arm one-shot and poll the done flag
  task one_shot(input integer sysref);
  integer k;
  begin
    r0 = rot_n;
    n0 = nco_n;
    wr(`SCASY_ADDR_ALIGN_MODE, 8'h02);
    if (sysref != 0) repeat (20) @(posedge mclk_i);
    if (sysref != 0) chki("early rotate", r0, rot_n);
    if (sysref != 0) peer.send_sysref;
    v = 8'h00;
    for (k = 0; k < 40 && v[4] !== 1'b1; k = k + 1)
    begin
      @(posedge mclk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= `SCASY_ADDR_ALIGN_MODE;
      @(posedge mclk_i);
      reg_rd_i   <= 1'b0;
      #1 v = reg_rdata_o;
    end
    repeat (2) @(posedge mclk_i);
    chki("rotations", r0 + 1, rot_n);
    rchk(`SCASY_ADDR_ALIGN_MODE, 8'h10);
  end
  endtask
  // Leader sync with one control setting
  task lead(input [7:0] cc);
  integer k;
  begin
    wr(`SCASY_ADDR_LF_CTRL, cc);
    wr(`SCASY_ADDR_TRIG, 8'h01);
    #1 n0 = nco_n;
    d = lr_n;
    if (cc[3:2] == 2'h0) rchk(`SCASY_ADDR_TRIG, 8'h01);
    if (cc[3:2] == 2'h0) peer.send_sysref;
    for (k = 0; k < 300 && nco_n == n0; k = k + 1)
      @(posedge mclk_i);
    d = lr_n - d;
    chki("leader nco", n0 + 1, nco_n);
    rchk(`SCASY_ADDR_TRIG, 8'h00);
  end
  endtask
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    {mclk_i, rst_n_i, reg_wr_i, reg_rd_i, subclass1_i} = 5'h00;
    {jesd_period_en_i, lm_q, down_at} = 4'h0;
    {reg_addr_i, reg_wdata_i} = 16'h0000;
    {err_count, check_count, cyc, rot_n, nco_n} = 160'h0;
    {txs_n, rxs_n, lr_n, lo_n, last_r, per_q} = 192'h0;
    do_reset;
    rchk(`SCASY_ADDR_ALIGN_MODE, 8'h00);
    rchk(`SCASY_ADDR_ROTATION, 8'h30);
    rchk(`SCASY_ADDR_AVERAGE, 8'h00);
    rchk(`SCASY_ADDR_TRIG, 8'h00);
    rchk(`SCASY_ADDR_RATIO, 8'h00);
    rchk(`SCASY_ADDR_AVG_PATH, 8'h07);
    rchk(`SCASY_ADDR_PERIOD_LO, 8'h80);
    rchk(`SCASY_ADDR_PERIOD_HI, 8'h01);
    rchk(`SCASY_ADDR_EDGE_SEL, 8'h15);
    rchk(`SCASY_ADDR_LF_CTRL, 8'h04);
    rchk(8'h50, 8'h00);
    wr(`SCASY_ADDR_ROTATION, 8'hFF);
    rchk(`SCASY_ADDR_ROTATION, 8'h33);
    wr(`SCASY_ADDR_PERIOD_HI, 8'hFF);
    rchk(`SCASY_ADDR_PERIOD_HI, 8'h17);
    wr(`SCASY_ADDR_LF_CTRL, 8'hFF);
    rchk(`SCASY_ADDR_LF_CTRL, 8'hFF);
    wr(`SCASY_ADDR_AVG_PATH, 8'hFF);
    rchk(`SCASY_ADDR_AVG_PATH, 8'h27);
    $display("test registers done");
    do_reset;
    wr(`SCASY_ADDR_AVERAGE, 8'h03);
    wr(`SCASY_ADDR_AVG_PATH, 8'h27);
    wr(`SCASY_ADDR_RATIO, 8'h05);
    for (m = 0; m < 4; m = m + 1)
    begin
      wr(`SCASY_ADDR_ROTATION, 8'h10 | m);
      one_shot(0);
      chki("nco after align", n0 + 1, nco_n);
      chk8("power", {6'h00, m[1:0]}, {6'h00, down_at});
      chk8("restored", 8'h00, {6'h00, dp_off_o, link_down_o});
    end
    subclass1_i <= 1'b1;
    wr(`SCASY_ADDR_ROTATION, 8'h00);
    one_shot(1);
    chki("nco with reset off", n0, nco_n);
    subclass1_i <= 1'b0;
    wr(`SCASY_ADDR_ALIGN_MODE, 8'h01);
    r0 = rot_n;
    peer.send_sysref;
    repeat (10) @(posedge mclk_i);
    peer.send_sysref;
    repeat (20) @(posedge mclk_i);
    chki("continuous", r0 + 2, rot_n);
    wr(`SCASY_ADDR_ALIGN_MODE, 8'h00);
    $display("test rotation done");
    wr(`SCASY_ADDR_PERIOD_LO, 8'h04);
    wr(`SCASY_ADDR_PERIOD_HI, 8'h10);
    repeat (60) @(posedge mclk_i);
    p4 = per_q;
    wr(`SCASY_ADDR_PERIOD_LO, 8'h08);
    repeat (120) @(posedge mclk_i);
    chki("period ratio", 2 * p4, per_q);
    for (m = 0; m < 3; m = m + 1)
    begin
      wr(`SCASY_ADDR_EDGE_SEL, {4'h1, m[1:0], m[1:0]});
      n0 = txs_n;
      r0 = rxs_n;
      peer.send_sysref;
      repeat (60) @(posedge mclk_i);
      chki("tx sync", n0 + 1, txs_n);
      chki("rx sync", r0 + 1, rxs_n);
    end
    $display("test sync edge done");
    wr(`SCASY_ADDR_GPIO_CFG0, 8'h0A);
    repeat (3) @(posedge mclk_i);
    chk8("pin enable", 8'h01, {2'h0, gpio_oe_o});
    r0 = lo_n;
    lead(8'h01);
    chki("leader pin", r0 + 1, lo_n);
    lead(8'h05);
    lead(8'h09);
    lead(8'h35);
    chki("extra frames", 1, (d >= 3 && d <= 4));
    wr(`SCASY_ADDR_GPIO_CFG0, 8'hB0);
    wr(`SCASY_ADDR_LF_CTRL, 8'h02);
    n0 = nco_n;
    peer.send_sync(6'h02);
    repeat (10) @(posedge mclk_i);
    chki("follower nco", n0 + 1, nco_n);
    chk8("pin enable", 8'h00, {2'h0, gpio_oe_o});
    wr(`SCASY_ADDR_LF_CTRL, 8'h03);
    n0 = nco_n;
    peer.send_sync(6'h02);
    repeat (10) @(posedge mclk_i);
    chki("disabled nco", n0, nco_n);
    wr(`SCASY_ADDR_TRIG, 8'h01);
    repeat (2) @(posedge mclk_i);
    rchk(`SCASY_ADDR_TRIG, 8'h00);
    $display("test leader follower done");
    stop_test;
  end
endmodule
